/* File: bench/tb_touch_adc_channel_decoder.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) \
	begin \
		check_count++; \
		if ((g) !== (e)) begin \
			errors++; \
			$display("mismatch %s exp %0h got %0h", nm, e, g); \
		end \
	end
module tb_touch_adc_channel_decoder;
	import touch_pkg::*;
	logic              core_clk = 1'b0;
	logic              nrst = 1'b0;
	logic              cs_n, dclk, din;
	logic [LVL_W-1:0]  pos_lv, neg_lv, refp_lv, refn_lv;
	in_sel_t           pos_in_sel;
	ref_sel_t          ref_p_sel, ref_n_sel;
	logic              xp, xm, yp, ym, bias_lo, bias_hi, vbat_on, ref_on;
	logic              sample_on, busy;
	logic [CODE_W-1:0] result_code;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata;
	logic              we, re;
	int                errors = 0, check_count = 0;
	logic [12:0]       route_now;
	localparam logic [12:0] IDLE_R = {in_none, ref_vref, ref_gnd, 4'h0};

	assign route_now = {pos_in_sel, ref_p_sel, ref_n_sel, xp, xm, yp, ym};

	touch_host_model host_u (.core_clk(core_clk), .cs_n_pin(cs_n),
		.dclk_pin(dclk), .din_pin(din));

	touch_adc_channel_decoder dut_u (.core_clk(core_clk), .nrst(nrst),
		.cs_n_pin(cs_n), .dclk_pin(dclk), .din_pin(din),
		.pos_level(pos_lv), .neg_level(neg_lv), .refp_level(refp_lv),
		.refn_level(refn_lv), .pos_in_sel(pos_in_sel),
		.ref_p_sel(ref_p_sel), .ref_n_sel(ref_n_sel), .drv_xp_on(xp),
		.drv_xm_on(xm), .drv_yp_on(yp), .drv_ym_on(ym),
		.temp_diode_low_bias(bias_lo), .temp_diode_high_bias(bias_hi),
		.vbat_div_on(vbat_on), .int_ref_on(ref_on), .sample_on(sample_on),
		.busy(busy), .result_code(result_code), .bus_addr(addr),
		.bus_wdata(wdata), .bus_we(we), .bus_re(re), .bus_rdata(rdata));

	always #50 core_clk = ~core_clk;

	// expected {mux, ref plus, ref minus, xp xm yp ym}
	function automatic logic [12:0] exp_route(input logic [2:0] c,
		input logic m);
		logic [2:0] sel;
		logic [3:0] d;
		logic [5:0] rf;
		rf = {ref_vref, ref_gnd};
		case (c)
			3'h0: {sel, d} = {in_temp_diode_low_bias, 4'h0};
			3'h1: {sel, d} = {in_xp, 4'h3};
			3'h2: {sel, d} = {in_vbat, 4'h0};
			3'h3: {sel, d} = {in_xp, 4'h6};
			3'h4: {sel, d} = {in_ym, 4'h6};
			3'h5: {sel, d} = {in_yp, 4'hc};
			3'h6: {sel, d} = {in_aux, 4'h0};
			default: {sel, d} = {in_temp_diode_high_bias, 4'h0};
		endcase
		if (!m) begin
			case (c)
				3'h1, 3'h3: rf = {ref_yp, ref_ym};
				3'h4: rf = {ref_yp, ref_xm};
				3'h5: rf = {ref_xp, ref_xm};
				default: rf = {ref_vref, ref_gnd};
			endcase
		end
		return {sel, rf, d};
	endfunction : exp_route

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge core_clk);
		we <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge core_clk);
		we <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		@(posedge core_clk);
		re <= 1'b1;
		addr <= a;
		@(posedge core_clk);
		re <= 1'b0;
		#1;
		`CHK("rdata", e, rdata)
	endtask : rd

	task automatic levels(input logic [LVL_W-1:0] p, n, rp, rn);
		@(posedge core_clk);
		pos_lv <= p;
		neg_lv <= n;
		refp_lv <= rp;
		refn_lv <= rn;
	endtask : levels

	task automatic t_reset();
		`CHK("route", IDLE_R, route_now)
		`CHK("ref_on", 1'b0, ref_on)
		`CHK("busy", 1'b0, busy)
		rd(OFF_CTRL, CTRL_RESET);
		rd(OFF_STATUS, 32'h0000_0008);
		wr(OFF_STATUS, 32'h0000_00ff);
		rd(OFF_STATUS, 32'h0000_0008);
		rd(8'h10, 32'h0000_0000);
		$display("test reset done");
	endtask : t_reset

	task automatic t_codes();
		logic [LVL_W-1:0] p;
		for (int m = 1; m >= 0; m--) begin
			for (int c = 0; c < 8; c++) begin
				if (m == 0 && !(c inside {1, 3, 4, 5})) continue;
				p = 16'(c + 1) << 8;
				levels(p, 16'h0080, 16'h1000, 16'h0000);
				host_u.send({3'(c), 1'b0, 1'(m), 2'b00});
				repeat (2) @(posedge core_clk);
				`CHK("route", exp_route(3'(c), 1'(m)), route_now)
				`CHK("sample", 1'b1, sample_on)
				`CHK("bias", {c == 0, c == 7, c == 2}, {bias_lo, bias_hi, vbat_on})
				host_u.tick(2);
				`CHK("sample", 1'b1, sample_on)
				host_u.tick(1);
				repeat (2) @(posedge core_clk);
				`CHK("phase", 2'b01, {sample_on, busy})
				`CHK("bias", 3'h0, {bias_lo, bias_hi, vbat_on})
				rd(OFF_HELD, 32'(p - 16'h0080));
				host_u.tick(12);
				repeat (2) @(posedge core_clk);
				`CHK("result", 12'(p - 16'h0080), result_code)
				`CHK("route", IDLE_R, route_now)
				host_u.release_link();
			end
		end
		$display("test codes done");
	endtask : t_codes

	// clamps at both ends and a half-size span
	task automatic t_clamp();
		logic [15:0] pv [3] = '{16'h0100, 16'h2000, 16'h0400};
		logic [15:0] nv [3] = '{16'h0200, 16'h0000, 16'h0000};
		logic [15:0] rv [3] = '{16'h1000, 16'h1000, 16'h0c00};
		logic [15:0] rn [3] = '{16'h0000, 16'h0000, 16'h0400};
		logic [11:0] ev [3] = '{12'h000, 12'hfff, 12'h800};
		for (int i = 0; i < 3; i++) begin
			levels(pv[i], nv[i], rv[i], rn[i]);
			host_u.send(7'b110_0_1_0_0);
			host_u.tick(15);
			repeat (2) @(posedge core_clk);
			`CHK("result", ev[i], result_code)
			host_u.release_link();
		end
		$display("test clamp done");
	endtask : t_clamp

	task automatic t_power();
		levels(16'h0300, 16'h0100, 16'h1000, 16'h0000);
		host_u.send(7'b011_0_0_1_1);
		repeat (2) @(posedge core_clk);
		`CHK("ref_on", 1'b1, ref_on)
		rd(OFF_STATUS, 32'h0000_0073);
		host_u.tick(15);
		repeat (2) @(posedge core_clk);
		`CHK("route", exp_route(3'h3, 1'b0), route_now)
		`CHK("result", 12'h200, result_code)
		host_u.release_link();
		host_u.send(7'b110_0_1_0_0);
		repeat (2) @(posedge core_clk);
		`CHK("ref_on", 1'b0, ref_on)
		`CHK("route", exp_route(3'h6, 1'b1), route_now)
		host_u.tick(15);
		repeat (2) @(posedge core_clk);
		`CHK("route", IDLE_R, route_now)
		host_u.release_link();
		$display("test power done");
	endtask : t_power

	// deselect mid-acquisition, then a frame with the link disabled
	task automatic t_abort();
		levels(16'h0f00, 16'h0000, 16'h1000, 16'h0000);
		host_u.send(7'b010_0_1_0_0);
		host_u.tick(1);
		host_u.release_link();
		`CHK("busy", 2'b00, {busy, sample_on})
		`CHK("result", 12'h200, result_code)
		wr(OFF_CTRL, 32'h0000_0000);
		rd(OFF_CTRL, 32'h0000_0000);
		host_u.send(7'b010_0_1_0_0);
		repeat (2) @(posedge core_clk);
		`CHK("busy", 1'b0, busy)
		`CHK("route", IDLE_R, route_now)
		host_u.release_link();
		wr(OFF_CTRL, CTRL_RESET);
		rd(OFF_CTRL, CTRL_RESET);
		$display("test abort done");
	endtask : t_abort

	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_sim

	initial begin
		pos_lv  <= '0;
		neg_lv  <= '0;
		refp_lv <= '0;
		refn_lv <= '0;
		addr    <= '0;
		wdata   <= '0;
		we      <= 1'b0;
		re      <= 1'b0;
		repeat (12) @(posedge core_clk);
		nrst <= 1'b1;
		repeat (4) @(posedge core_clk);
		t_reset();
		t_codes();
		t_clamp();
		t_power();
		t_abort();
		end_sim();
	end

	// about 20 frames of about 220 cycles are expected
	initial begin
		repeat (20000) @(posedge core_clk);
		errors++;
		end_sim();
	end
endmodule : tb_touch_adc_channel_decoder

/* File: bench/touch_host_model.sv */
`timescale 1ns/1ps
module touch_host_model (
	// clock
	input  wire logic core_clk,
	// link pins
	output logic      cs_n_pin,
	output logic      dclk_pin,
	output logic      din_pin
);
	initial begin
		cs_n_pin = 1'b1;
		dclk_pin = 1'b0;
		din_pin  = 1'b1;
	end

	// one link clock rise, period 9 core cycles (900 ns)
	task automatic rise(input logic b);
		@(posedge core_clk);
		dclk_pin <= 1'b0;
		din_pin  <= b;
		repeat (4) @(posedge core_clk);
		dclk_pin <= 1'b1;
		repeat (4) @(posedge core_clk);
	endtask : rise

	// start bit then seven command bits, msb first
	task automatic send(input logic [6:0] cmd);
		@(posedge core_clk);
		cs_n_pin <= 1'b0;
		rise(1'b1);
		for (int i = 6; i >= 0; i--) begin
			rise(cmd[i]);
		end
	endtask : send

	// data pin is ignored now, so keep it moving
	task automatic tick(input int n);
		for (int i = 0; i < n; i++) begin
			rise(~din_pin);
		end
	endtask : tick

	// clock stands still between frames
	task automatic release_link();
		@(posedge core_clk);
		dclk_pin <= 1'b0;
		cs_n_pin <= 1'b1;
		din_pin  <= ~din_pin;
		repeat (8) @(posedge core_clk);
	endtask : release_link
endmodule : touch_host_model

/* File: src/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
	parameter int         W       = 3,
	parameter logic [2:0] RST_VAL = 3'h4
) (
	// clock and reset
	input  wire logic         core_clk,
	input  wire logic         nrst,
	// pins in, synchronised out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;

	// first stage feeds only the second
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			meta_q <= RST_VAL[W-1:0];
			q      <= RST_VAL[W-1:0];
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule : pin_sync

/* File: src/route_decode.sv */
`timescale 1ns/1ps
module route_decode
	import touch_pkg::*;
(
	// decoded command
	input  touch_pkg::cmd_t   cmd,
	// input configuration
	output touch_pkg::route_t route
);
	always_comb begin
		route = ROUTE_IDLE;
		// single-ended default: reference pins, no drivers
		case (cmd.chan)
			3'h0: route.in_sel = in_temp_diode_low_bias;                          // [R5]
			3'h1: begin                                            // [R6]
				route.in_sel = in_xp;
				route.yp     = 1'b1;                                // [R8]
				route.ym     = 1'b1;
			end
			3'h2: route.in_sel = in_vbat;                           // [R5]
			3'h3: begin                                            // [R6]
				route.in_sel = in_xp;
				route.xm     = 1'b1;
				route.yp     = 1'b1;
			end
			3'h4: begin                                            // [R6]
				route.in_sel = in_ym;
				route.xm     = 1'b1;
				route.yp     = 1'b1;
			end
			3'h5: begin                                            // [R6]
				route.in_sel = in_yp;
				route.xp     = 1'b1;                                // [R9]
				route.xm     = 1'b1;
			end
			3'h6: route.in_sel = in_aux;                            // [R5]
			default: route.in_sel = in_temp_diode_high_bias;                       // [R5]
		endcase
		// differential: references follow the driven pair, except 011, which takes Y+ and Y-
		if (!cmd.ref_mode) begin
			case (cmd.chan)
				3'h1: begin                                        // [R7]
					route.ref_p = ref_yp;
					route.ref_n = ref_ym;
				end
				3'h3: begin                                        // [R7]
					route.ref_p = ref_yp;
					route.ref_n = ref_ym;
				end
				3'h4: begin                                        // [R7]
					route.ref_p = ref_yp;
					route.ref_n = ref_xm;
				end
				3'h5: begin                                        // [R7]
					route.ref_p = ref_xp;
					route.ref_n = ref_xm;
				end
				// other codes keep the single-ended routing [R15]
				default: route.ref_p = ref_vref;
			endcase
		end
	end
endmodule : route_decode

/* File: src/touch_adc_channel_decoder.sv */
// Functional notes
// (R1) Input configuration comes only from channel bits and reference mode bit.
// (R2) Command bits arrive serially on the data pin; configuration taken from them.
// (R3) The host supplies the conversion clock; no internal clock source.
// (R4) Entering hold captures positive minus negative input for the conversion.
// (R5) Single-ended 000/010/110/111 pick temp_diode_low_bias, battery, aux, temp_diode_high_bias; drivers off.
// (R6) Single-ended 001 Y, 011 Z1, 100 Z2, 101 X; 011/100 drive X- and Y+.
// (R7) Differential mode references follow each measurement's driven pin pair. Code gives 011 the Y+ and Y- references, not X- and Y+.
// (R8) Y position: X+ to converter, Y+ and Y- drivers on.
// (R9) Unselected input pins may drive the panel as supply and ground.
// (R10) Internal reference power follows the command's reference power bit.
// (R11) After power-up host sends a command with reference power bit cleared.
// (R12) Code weight is reference span over 4096, straight binary.
// (R13) Acquisition with diode bias lasts three link clock cycles.
// (R14) Hold bit set keeps panel drivers on between conversions.
// (R15) Host uses only panel codes in differential mode.
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module touch_adc_channel_decoder
	import touch_pkg::*;
(
	// clock and reset
	input  wire logic                     core_clk,
	input  wire logic                     nrst,
	// serial link pins
	input  wire logic                     cs_n_pin,
	input  wire logic                     dclk_pin,
	input  wire logic                     din_pin,
	// analog front end levels
	input  wire logic [touch_pkg::LVL_W-1:0] pos_level,
	input  wire logic [touch_pkg::LVL_W-1:0] neg_level,
	input  wire logic [touch_pkg::LVL_W-1:0] refp_level,
	input  wire logic [touch_pkg::LVL_W-1:0] refn_level,
	// multiplexer and panel drivers
	output touch_pkg::in_sel_t            pos_in_sel,
	output touch_pkg::ref_sel_t           ref_p_sel,
	output touch_pkg::ref_sel_t           ref_n_sel,
	output logic                          drv_xp_on,
	output logic                          drv_xm_on,
	output logic                          drv_yp_on,
	output logic                          drv_ym_on,
	// bias, divider, reference, phase
	output logic                          temp_diode_low_bias,
	output logic                          temp_diode_high_bias,
	output logic                          vbat_div_on,
	output logic                          int_ref_on,
	output logic                          sample_on,
	output logic                          busy,
	output logic [touch_pkg::CODE_W-1:0]  result_code,
	// register port
	input  wire logic [touch_pkg::ADDR_W-1:0] bus_addr,
	input  wire logic [touch_pkg::DATA_W-1:0] bus_wdata,
	input  wire logic                     bus_we,
	input  wire logic                     bus_re,
	output logic [touch_pkg::DATA_W-1:0]  bus_rdata
);
	import touch_pkg::*;

	link_t               link_s;
	logic                dclk_prev_q;
	logic                dclk_rise;
	conv_state_t         state_q;
	conv_state_t         state_d;
	logic [CNT_W-1:0]    cnt_q;
	logic                phase_last;
	logic [CMD_BITS-2:0] shift_q;
	logic [CMD_BITS-1:0] cmd_bits;
	cmd_t                cmd_q;
	cmd_t                cmd_new;
	cmd_t                cmd_d;
	route_t              route_w;
	route_t              route_d;
	logic [LVL_W-1:0]    held_q;
	logic [LVL_W-1:0]    span_q;
	logic [DATA_W-1:0]   ctrl_q;
	logic [DATA_W-1:0]   status_w;
	logic                link_en;

	function automatic logic [LVL_W-1:0] pos_diff(
		input logic [LVL_W-1:0] a,
		input logic [LVL_W-1:0] b
	);
		pos_diff = (a > b) ? (a - b) : '0;
	endfunction : pos_diff

	// span of zero saturates rather than divide by zero
	function automatic logic [CODE_W-1:0] calc_code(
		input logic [LVL_W-1:0] d,
		input logic [LVL_W-1:0] s
	);
		logic [LVL_W+CODE_W-1:0] num;
		logic [LVL_W+CODE_W-1:0] quo;
		num = {d, {CODE_W{1'b0}}};
		quo = '0;
		if (s == '0) begin
			calc_code = CODE_MAX;
		end else begin
			quo = num / {{CODE_W{1'b0}}, s};
			if (quo > {{LVL_W{1'b0}}, CODE_MAX}) begin
				calc_code = CODE_MAX;
			end else begin
				calc_code = quo[CODE_W-1:0];
			end
		end
	endfunction : calc_code

	// the link clock is only sampled, never used as a clock [R3]
	pin_sync #(
		.W       (3),
		.RST_VAL (LINK_IDLE)
	) u_sync (
		.core_clk (core_clk),
		.nrst     (nrst),
		.d        ({cs_n_pin, dclk_pin, din_pin}),
		.q        (link_s)
	);

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			dclk_prev_q <= 1'b0;
		end else begin
			dclk_prev_q <= link_s.dclk;
		end
	end

	assign dclk_rise = link_s.dclk & ~dclk_prev_q;
	assign link_en   = ctrl_q[CTRL_LINK_EN];

	always_comb begin
		case (state_q)
			st_cmd:  phase_last = (cnt_q == CNT_W'(CMD_BITS - 1));
			st_acq:  phase_last = (cnt_q == CNT_W'(ACQ_DCLK - 1));   // [R13]
			st_conv: phase_last = (cnt_q == CNT_W'(CONV_DCLK - 1));
			default: phase_last = 1'b0;
		endcase
	end

	always_comb begin
		state_d = state_q;
		if (link_s.cs_n || !link_en) begin
			state_d = st_idle;
		end else if (dclk_rise) begin
			case (state_q)
				st_idle: if (link_s.din) begin                     // [R2]
					state_d = st_cmd;
				end
				st_cmd:  if (phase_last) begin
					state_d = st_acq;
				end
				st_acq:  if (phase_last) begin                     // [R13]
					state_d = st_conv;
				end
				st_conv: if (phase_last) begin
					state_d = st_idle;
				end
				default: state_d = st_idle;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state_q <= st_idle;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			cnt_q <= '0;
		end else if (state_d != state_q || state_q == st_idle) begin
			cnt_q <= '0;
		end else if (dclk_rise) begin
			cnt_q <= cnt_q + CNT_W'(1);
		end
	end

	// command shifter, msb first [R2]
	assign cmd_bits = {shift_q, link_s.din};
	assign cmd_new  = '{cmd_bits[CMD_CHAN_MSB:CMD_CHAN_LSB],
		cmd_bits[CMD_REF_MODE], cmd_bits[CMD_REF_PWR], cmd_bits[CMD_HOLD]};

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			shift_q <= '0;
		end else if (state_q == st_cmd && dclk_rise) begin
			shift_q <= cmd_bits[CMD_BITS-2:0];
		end
	end

	assign cmd_d = (state_q == st_cmd && state_d == st_acq) ? cmd_new
		: cmd_q;

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			cmd_q <= CMD_RESET;
		end else if (state_q == st_cmd && state_d == st_acq) begin
			cmd_q <= cmd_new;                                     // [R1] [R2]
		end
	end

	// reference power from the latest command; host clears it [R10] [R11]
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			int_ref_on <= 1'b0;
		end else if (state_q == st_cmd && state_d == st_acq) begin
			int_ref_on <= cmd_new.ref_pwr;                         // [R10]
		end
	end

	route_decode u_route (
		.cmd   (cmd_d),
		.route (route_w)
	);

	// drivers live during a conversion, and after it only when held
	always_comb begin
		if (state_d == st_acq || state_d == st_conv) begin
			route_d = route_w;                                    // [R1] [R9]
		end else if (cmd_q.hold) begin
			route_d = route_w;                                    // [R14]
		end else begin
			route_d = ROUTE_IDLE;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			pos_in_sel <= in_none;
			ref_p_sel  <= ref_vref;
			ref_n_sel  <= ref_gnd;
			drv_xp_on  <= 1'b0;
			drv_xm_on  <= 1'b0;
			drv_yp_on  <= 1'b0;
			drv_ym_on  <= 1'b0;
		end else begin
			pos_in_sel <= route_d.in_sel;
			ref_p_sel  <= route_d.ref_p;
			ref_n_sel  <= route_d.ref_n;
			drv_xp_on  <= route_d.xp;
			drv_xm_on  <= route_d.xm;
			drv_yp_on  <= route_d.yp;
			drv_ym_on  <= route_d.ym;
		end
	end

	// bias and divider only in acquisition, saving power
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			sample_on            <= 1'b0;
			busy                 <= 1'b0;
			temp_diode_low_bias  <= 1'b0;
			temp_diode_high_bias <= 1'b0;
			vbat_div_on          <= 1'b0;
		end else begin
			sample_on            <= (state_d == st_acq);          // [R13]
			busy                 <= (state_d == st_acq) ||
				(state_d == st_conv);
			temp_diode_low_bias  <= (state_d == st_acq) &&
				(route_w.in_sel == in_temp_diode_low_bias);                     // [R13]
			temp_diode_high_bias <= (state_d == st_acq) &&
				(route_w.in_sel == in_temp_diode_high_bias);                     // [R13]
			vbat_div_on          <= (state_d == st_acq) &&
				(route_w.in_sel == in_vbat);
		end
	end

	// hold: freeze input difference and reference span [R4]
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			held_q <= '0;
			span_q <= '0;
		end else if (state_q == st_acq && state_d == st_conv) begin
			held_q <= pos_diff(pos_level, neg_level);             // [R4]
			span_q <= pos_diff(refp_level, refn_level);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			result_code <= '0;
		end else if (state_q == st_conv && state_d == st_idle) begin
			result_code <= calc_code(held_q, span_q);             // [R12]
		end
	end

	// register port
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			ctrl_q <= CTRL_RESET;
		end else if (bus_we && bus_addr == OFF_CTRL) begin
			ctrl_q <= {31'h0, bus_wdata[CTRL_LINK_EN]};
		end
	end

	always_comb begin
		status_w = '0;
		status_w[ST_CHAN_LSB +: 3] = cmd_q.chan;
		status_w[ST_REF_MODE]      = cmd_q.ref_mode;
		status_w[ST_REF_ON]        = int_ref_on;
		status_w[ST_HOLD]          = cmd_q.hold;
		status_w[ST_BUSY]          = busy;
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			bus_rdata <= '0;
		end else if (bus_re) begin
			case (bus_addr)
				OFF_CTRL:   bus_rdata <= ctrl_q;
				OFF_STATUS: bus_rdata <= status_w;
				OFF_RESULT: bus_rdata <= {20'h0, result_code};
				OFF_HELD:   bus_rdata <= {16'h0, held_q};
				default:    bus_rdata <= '0;
			endcase
		end else begin
			bus_rdata <= '0;
		end
	end

	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	logic [CNT_W-1:0] acq_edges_q;
	always_ff @(posedge core_clk) begin
		if (!nrst || state_q != st_acq) begin
			acq_edges_q <= '0;
		end else if (dclk_rise) begin
			acq_edges_q <= acq_edges_q + CNT_W'(1);
		end
	end

	a_acq_three_edges: assert property (                    // [R13]
		state_q == st_acq && state_d == st_conv |-> acq_edges_q == 4'h2)
		else $error("acquisition length wrong");
	a_hold_capture: assert property (                       // [R4]
		state_q == st_acq && state_d == st_conv
		|=> held_q == pos_diff($past(pos_level), $past(neg_level)))
		else $error("held difference wrong");
	a_result_weight: assert property (                      // [R12]
		state_q == st_conv && state_d == st_idle
		|=> result_code == calc_code($past(held_q), $past(span_q)))
		else $error("result code wrong");
	a_ref_power: assert property (                          // [R10]
		state_q == st_cmd && state_d == st_acq
		|=> int_ref_on == $past(shift_q[0]) ##1 $stable(int_ref_on)[*2])
		else $error("reference power not from command");
	a_y_measure: assert property (                          // [R8]
		busy && cmd_q.chan == 3'h1 |-> pos_in_sel == in_xp &&
		drv_yp_on && drv_ym_on && !drv_xp_on && !drv_xm_on)
		else $error("y position routing wrong");
	a_single_ended: assert property (                       // [R5]
		busy && cmd_q.ref_mode && cmd_q.chan == 3'h2
		|-> pos_in_sel == in_vbat && ref_p_sel == ref_vref &&
		!(drv_xp_on | drv_xm_on | drv_yp_on | drv_ym_on))
		else $error("battery routing wrong");
	a_diff_refs: assert property (                          // [R7]
		busy && !cmd_q.ref_mode && cmd_q.chan == 3'h4
		|-> ref_p_sel == ref_yp && ref_n_sel == ref_xm && drv_xm_on)
		else $error("z2 differential references wrong");
	a_drivers_idle: assert property (                       // [R14]
		state_q == st_conv && state_d == st_idle && !cmd_q.hold
		|=> !(drv_xp_on | drv_xm_on | drv_yp_on | drv_ym_on))
		else $error("drivers left on without hold");
	a_drivers_held: assert property (                       // [R14]
		state_q == st_conv && state_d == st_idle && cmd_q.hold
		&& cmd_q.chan == 3'h3 |=> drv_xm_on && drv_yp_on)
		else $error("drivers dropped with hold");
	a_bias_in_acq: assert property (                        // [R13]
		temp_diode_low_bias || temp_diode_high_bias |-> sample_on)
		else $error("diode bias outside acquisition");

	c_conv_single: cover property (
		state_q == st_conv && state_d == st_idle && cmd_q.ref_mode);
	c_conv_diff: cover property (
		state_q == st_conv && state_d == st_idle && !cmd_q.ref_mode);
	c_hold_kept: cover property (
		!busy && cmd_q.hold && drv_yp_on);
	c_temp_bias: cover property (temp_diode_high_bias);
endmodule : touch_adc_channel_decoder

/* File: src/touch_pkg.sv */
package touch_pkg;

	// register port geometry
	localparam int          ADDR_W      = 8;
	localparam int          DATA_W      = 32;
	localparam logic [7:0]  OFF_CTRL    = 8'h00;
	localparam logic [7:0]  OFF_STATUS  = 8'h04;
	localparam logic [7:0]  OFF_RESULT  = 8'h08;
	localparam logic [7:0]  OFF_HELD    = 8'h0c;
	localparam logic [31:0] CTRL_RESET  = 32'h0000_0001;
	localparam int          CTRL_LINK_EN = 0;

	// status field positions
	localparam int ST_CHAN_LSB = 0;
	localparam int ST_REF_MODE = 3;
	localparam int ST_REF_ON   = 4;
	localparam int ST_HOLD     = 5;
	localparam int ST_BUSY     = 6;

	// command bits after the start bit, first received is msb
	localparam int CMD_BITS     = 7;
	localparam int CMD_CHAN_MSB = 6;
	localparam int CMD_CHAN_LSB = 4;
	localparam int CMD_REF_MODE = 2;
	localparam int CMD_REF_PWR  = 1;
	localparam int CMD_HOLD     = 0;

	// phase lengths in link clock cycles
	localparam int ACQ_DCLK  = 3;
	localparam int CONV_DCLK = 12;
	localparam int CNT_W     = 4;

	// converter arithmetic
	localparam int          CODE_W   = 12;
	localparam int          LVL_W    = 16;
	localparam logic [11:0] CODE_MAX = 12'hfff;

	typedef enum logic [2:0] {
		in_none, in_temp_diode_low_bias, in_temp_diode_high_bias, in_vbat, in_aux, in_xp, in_yp, in_ym
	} in_sel_t;

	typedef enum logic [2:0] {
		ref_vref, ref_gnd, ref_xp, ref_xm, ref_yp, ref_ym
	} ref_sel_t;

	typedef enum logic [1:0] {
		st_idle, st_cmd, st_acq, st_conv
	} conv_state_t;

	typedef struct packed {
		logic [2:0] chan;
		logic       ref_mode;
		logic       ref_pwr;
		logic       hold;
	} cmd_t;

	typedef struct packed {
		in_sel_t  in_sel;
		ref_sel_t ref_p;
		ref_sel_t ref_n;
		logic     xp;
		logic     xm;
		logic     yp;
		logic     ym;
	} route_t;

	typedef struct packed {
		logic cs_n;
		logic dclk;
		logic din;
	} link_t;

	localparam cmd_t   CMD_RESET  = '{3'h0, 1'b1, 1'b0, 1'b0};
	localparam route_t ROUTE_IDLE = '{in_none, ref_vref, ref_gnd,
		1'b0, 1'b0, 1'b0, 1'b0};
	localparam link_t  LINK_IDLE  = '{1'b1, 1'b0, 1'b0};

endpackage : touch_pkg
